// File: core/cfis_top.sv
// Top: APB slave holding the latched and live fault status registers
//
// The APB slave port was decided locally.
module cfis_top #(
    parameter int AW = 12
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire logic [7:0]    lat_a_events,
    input  wire logic [7:0]    lat_b_events,
    input  wire logic [7:0]    live_events,
    output logic               irq
);
    typedef struct packed {
        cfis_pkg::cfis_phase_e ph;
        logic                  pready_r;
        logic                  pslverr_r;
        logic [31:0]           prdata_r;
        logic [7:0]            live_r;
        logic [2:0]            stat_r;
        logic [2:0]            mask_r;
        logic                  irq_r;
    } cfis_top_s;

    cfis_top_s st;
    cfis_top_s st_nxt;

    cfis_flag_if #(.W(8)) lat_a_if ();
    cfis_flag_if #(.W(8)) lat_b_if ();

    // Address decode, shared by read mux, write path and read-clear
    function automatic logic cfis_hit(input logic [AW-1:0] a, input logic [7:0] idx);
        return a == AW'({idx, 2'b00});
    endfunction

    logic       setup;
    logic       done;
    logic       rd_done;
    logic [2:0] irq_set;
    logic [2:0] w1c;
    logic       mapped;
    logic [7:0] rd_byte;

    // Phase strobes; done marks the edge where the transfer takes effect
    assign setup   = psel && !penable;
    assign done    = psel && penable && st.pready_r;
    assign rd_done = done && !pwrite;

    // Event inputs into the two latched banks; read completion clears seen bits
    assign lat_a_if.ev       = lat_a_events;
    assign lat_b_if.ev       = lat_b_events;
    assign lat_a_if.clr      = rd_done && cfis_hit(paddr, cfis_pkg::IDX_LAT_A);
    assign lat_b_if.clr      = rd_done && cfis_hit(paddr, cfis_pkg::IDX_LAT_B);
    assign lat_a_if.clr_mask = st.prdata_r[7:0];
    assign lat_b_if.clr_mask = st.prdata_r[7:0];

    cfis_latch_bank #(.W(8)) u_lat_a (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (lat_a_if.bank)
    );

    cfis_latch_bank #(.W(8)) u_lat_b (
        .pclk    (pclk),
        .presetn (presetn),
        .fl      (lat_b_if.bank)
    );

    // Read mux and map check, evaluated in the setup cycle
    always_comb begin
        rd_byte = 8'h00;
        mapped  = 1'b1;
        if (cfis_hit(paddr, cfis_pkg::IDX_LAT_A)) begin
            rd_byte = lat_a_if.flags;
        end else if (cfis_hit(paddr, cfis_pkg::IDX_LAT_B)) begin
            rd_byte = lat_b_if.flags;
        end else if (cfis_hit(paddr, cfis_pkg::IDX_LIVE)) begin
            rd_byte = st.live_r;
        end else if (cfis_hit(paddr, cfis_pkg::IDX_IRQ_STAT)) begin
            rd_byte = {5'h00, st.stat_r};
        end else if (cfis_hit(paddr, cfis_pkg::IDX_IRQ_MASK)) begin
            rd_byte = {5'h00, st.mask_r};
        end else begin
            mapped = 1'b0;
        end
    end

    // New flag events raise the sticky interrupt status bits
    always_comb begin
        irq_set                      = 3'h0;
        irq_set[cfis_pkg::IRQ_LAT_A] = |(lat_a_events & ~lat_a_if.flags);
        irq_set[cfis_pkg::IRQ_LAT_B] = |(lat_b_events & ~lat_b_if.flags);
        irq_set[cfis_pkg::IRQ_LIVE]  = |(live_events & cfis_pkg::LIVE_USED & ~st.live_r);
        w1c = 3'h0;
        if (done && pwrite && pstrb[0] && cfis_hit(paddr, cfis_pkg::IDX_IRQ_STAT)) begin
            w1c = pwdata[2:0];
        end
    end

    // Next state: bus phase, live sampling, interrupt status and mask
    always_comb begin
        st_nxt        = st;
        // Reserved live bits are forced low whatever the inputs carry
        st_nxt.live_r = live_events & cfis_pkg::LIVE_USED;
        // Set wins over a same-cycle write-one-to-clear
        st_nxt.stat_r = (st.stat_r & ~w1c) | irq_set;
        if (done && pwrite && pstrb[0] && cfis_hit(paddr, cfis_pkg::IDX_IRQ_MASK)) begin
            st_nxt.mask_r = pwdata[2:0];
        end
        case (st.ph)
            cfis_pkg::PH_IDLE: begin
                if (setup) begin
                    st_nxt.ph        = cfis_pkg::PH_ACCESS;
                    st_nxt.pready_r  = 1'b1;
                    st_nxt.pslverr_r = !mapped;
                    st_nxt.prdata_r  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                end
            end
            cfis_pkg::PH_ACCESS: begin
                // Master holds its request until it sees ready
                if (done || !psel) begin
                    st_nxt.ph        = cfis_pkg::PH_IDLE;
                    st_nxt.pready_r  = 1'b0;
                    st_nxt.pslverr_r = 1'b0;
                end
            end
            default: begin
                st_nxt.ph       = cfis_pkg::PH_IDLE;
                st_nxt.pready_r = 1'b0;
            end
        endcase
        // Registered from next values so irq tracks status in the same cycle
        st_nxt.irq_r = |(st_nxt.stat_r & st_nxt.mask_r);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= '0;
            st.ph        <= cfis_pkg::PH_IDLE;
            st.live_r    <= cfis_pkg::FLAGS_RST;
            st.stat_r    <= cfis_pkg::IRQ_RST;
            st.mask_r    <= cfis_pkg::IRQ_RST;
        end else begin
            st <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign pready  = st.pready_r;
    assign prdata  = st.prdata_r;
    assign pslverr = st.pslverr_r;
    assign irq     = st.irq_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rd_a_done;
    assign rd_a_done = lat_a_if.clr;

    ovp_latch_a: assert property (
        (lat_a_events[cfis_pkg::LA_OV_C1P:cfis_pkg::LA_OV_C2M] != 4'h0) |=>
        ((lat_a_if.flags[7:4] & $past(lat_a_events[7:4])) == $past(lat_a_events[7:4])))
        else $error("Over-voltage event not latched");
    ovp_hold_a: assert property (
        (lat_a_if.flags[7:4] != 4'h0 && !rd_a_done) |=>
        ((lat_a_if.flags[7:4] & $past(lat_a_if.flags[7:4])) == $past(lat_a_if.flags[7:4])))
        else $error("Over-voltage flag dropped without a read");
    headset_latch_a: assert property (
        lat_a_events[cfis_pkg::LA_HS_INS] ##0 lat_a_events[cfis_pkg::LA_HS_HOOK] |=>
        lat_a_if.flags[cfis_pkg::LA_HS_INS] && lat_a_if.flags[cfis_pkg::LA_HS_HOOK])
        else $error("Headset event not latched");
    proc_latch_a: assert property (
        lat_a_events[cfis_pkg::LA_PROC_OVL] |=> lat_a_if.flags[cfis_pkg::LA_PROC_OVL] [*1]
        ##1 (rd_a_done || lat_a_if.flags[cfis_pkg::LA_PROC_OVL] || $past(rd_a_done)))
        else $error("Processing overload not latched");
    analog_latch_a: assert property (
        (lat_b_events[cfis_pkg::LB_ANA_UP] || lat_b_events[cfis_pkg::LB_ANA_LO]) |=>
        (lat_b_if.flags[cfis_pkg::LB_ANA_UP] || lat_b_if.flags[cfis_pkg::LB_ANA_LO]))
        else $error("Analog threshold event not latched");
    voice_latch_a: assert property (
        lat_b_events[cfis_pkg::LB_VOICE_UP] && !lat_b_events[cfis_pkg::LB_VOICE_DN]
        && !lat_b_if.flags[cfis_pkg::LB_VOICE_DN] |=>
        lat_b_if.flags[cfis_pkg::LB_VOICE_UP] && !lat_b_if.flags[cfis_pkg::LB_VOICE_DN])
        else $error("Voice activity flags crossed");
    micbias_latch_a: assert property (
        (lat_b_events[cfis_pkg::LB_MB_SHORT:cfis_pkg::LB_MB_OV] != 4'h0) |=>
        ((lat_b_if.flags[3:0] & $past(lat_b_events[3:0])) == $past(lat_b_events[3:0])))
        else $error("Mic bias fault not latched");
    live_clock_a: assert property (
        live_events[cfis_pkg::LV_CLK_ERR] ##1 !live_events[cfis_pkg::LV_CLK_ERR] |=>
        !st.live_r[cfis_pkg::LV_CLK_ERR] && $past(st.live_r[cfis_pkg::LV_CLK_ERR], 1))
        else $error("Live clock error not tracking input");
    live_boost_a: assert property (
        setup && cfis_hit(paddr, cfis_pkg::IDX_LIVE) && !pwrite |=>
        prdata[cfis_pkg::LV_BST_OT:cfis_pkg::LV_BST_MO] == $past(st.live_r[5:3])
        && prdata[cfis_pkg::LV_LOCK] == $past(st.live_r[cfis_pkg::LV_LOCK]))
        else $error("Live boost flags misread");
    live_rsvd_a: assert property (
        setup && cfis_hit(paddr, cfis_pkg::IDX_LIVE) |=> prdata[7:0] == (prdata[7:0] & 8'hf8))
        else $error("Reserved live bits not zero");
    read_clear_a: assert property (
        (rd_a_done && lat_a_events == 8'h00) |=> ((lat_a_if.flags & $past(prdata[7:0])) == 8'h00))
        else $error("Latched register not cleared by read");
    irq_level_a: assert property (
        irq == |(st.stat_r & st.mask_r))
        else $error("Interrupt output mismatch");

    read_clear_c: cover property (rd_a_done && prdata[7:0] != 8'h00 ##1 lat_a_if.flags == 8'h00);
    irq_raise_c:  cover property (!irq ##1 irq);
    back_back_c:  cover property (done ##1 setup);
    set_clear_c:  cover property (lat_b_if.clr && lat_b_events != 8'h00);
endmodule

// File: common/cfis_pkg.sv
// Package: register map, field positions and reset values of the fault status bank
package cfis_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_LAT_A    = 8'h3a;
    localparam logic [7:0] IDX_LAT_B    = 8'h3b;
    localparam logic [7:0] IDX_LIVE     = 8'h3c;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h41;

    // Reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [2:0] IRQ_RST   = 3'h0;

    // Live register: bits 7..3 carry flags, 2..0 are reserved and read zero
    localparam logic [7:0] LIVE_USED = 8'hf8;

    // Field positions, first latched register
    localparam int LA_OV_C1P   = 7;
    localparam int LA_OV_C2M   = 4;
    localparam int LA_HS_INS   = 3;
    localparam int LA_HS_HOOK  = 1;
    localparam int LA_PROC_OVL = 0;
    // Field positions, second latched register
    localparam int LB_ANA_UP   = 7;
    localparam int LB_ANA_LO   = 6;
    localparam int LB_VOICE_UP = 5;
    localparam int LB_VOICE_DN = 4;
    localparam int LB_MB_SHORT = 3;
    localparam int LB_MB_OV    = 0;
    // Field positions, live register
    localparam int LV_CLK_ERR  = 7;
    localparam int LV_LOCK     = 6;
    localparam int LV_BST_OT   = 5;
    localparam int LV_BST_MO   = 3;

    // Interrupt status / mask layout
    localparam int IRQ_LAT_A = 0;
    localparam int IRQ_LAT_B = 1;
    localparam int IRQ_LIVE  = 2;

    typedef enum logic {PH_IDLE, PH_ACCESS} cfis_phase_e;
endpackage

// File: common/cfis_flag_if.sv
// Interface: event, clear and flag signals between controller and a latched flag bank
interface cfis_flag_if #(parameter int W = 8);
    logic [W-1:0] ev;
    logic         clr;
    logic [W-1:0] clr_mask;
    logic [W-1:0] flags;

    modport bank (input ev, input clr, input clr_mask, output flags);
    modport ctrl (output ev, output clr, output clr_mask, input flags);
endinterface

// File: core/cfis_latch_bank.sv
// Bank of sticky flags that set on events and clear when the host has read them
module cfis_latch_bank #(
    parameter int W = 8
) (
    input wire logic   pclk,
    input wire logic   presetn,
    cfis_flag_if.bank  fl
);
    typedef struct packed {
        logic [W-1:0] flags_r;
    } cfis_bank_s;

    cfis_bank_s st;
    cfis_bank_s st_nxt;

    // Only bits the host actually saw are cleared; a live event always wins
    always_comb begin
        st_nxt         = st;
        st_nxt.flags_r = (st.flags_r & ~(fl.clr ? fl.clr_mask : '0)) | fl.ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= st_nxt;
        end
    end

    assign fl.flags = st.flags_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    set_wins_clear_a: assert property (
        (fl.ev != '0) |=> ((fl.flags & $past(fl.ev)) == $past(fl.ev)))
        else $error("Event lost in latched bank");
    flag_hold_a: assert property (
        (!fl.clr && fl.ev == '0) |=> (fl.flags == $past(fl.flags)))
        else $error("Latched flag changed without event or read");
    read_clear_a: assert property (
        (fl.clr && fl.ev == '0) |=> ((fl.flags & $past(fl.clr_mask)) == '0))
        else $error("Read flag not cleared");
endmodule

// File: testbench/cfis_host_model.sv
// Host model: APB master that polls and writes the fault status bank
module cfis_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hung;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        hung = 1'b0;
    end
    // One transfer; request held until pready is seen high, wait is bounded
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hung = (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// File: testbench/tb_top.sv
// Testbench: fault status bank driven by the host model, checked against expectations
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  ev_a, ev_b, ev_l, lfsr;
    int          n_fail, checked;

    cfis_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .lat_a_events(ev_a), .lat_b_events(ev_b),
        .live_events(ev_l), .irq(irq));
    cfis_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Bus access plus comparison of read data and error response
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] exp, input logic experr);
        host_u.xfer(wr, a, wd, rd, err);
        if (host_u.hung) begin
            n_fail++;
            give_verdict();
        end
        if (!wr) check("prdata", rd, exp);
        check("pslverr", {31'h0, err}, {31'h0, experr});
    endtask

    // Event held one cycle only, so the flag must latch it
    task automatic pulse(input int r, input int b);
        @(posedge pclk);
        if (r == 0) ev_a <= 8'h01 << b;
        else ev_b <= 8'h01 << b;
        @(posedge pclk);
        ev_a <= 8'h00;
        ev_b <= 8'h00;
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge pclk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    initial begin
        {presetn, ev_a, ev_b, ev_l, n_fail, checked} = '0;
        lfsr = 8'h16;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, 12'h0e8, 0, 32'h0, 1'b0);
        acc(1'b0, 12'h0ec, 0, 32'h0, 1'b0);
        acc(1'b0, 12'h0f0, 0, 32'h0, 1'b0);
        // Walk every latched bit: set, read once, then gone
        for (int r = 0; r < 2; r++) begin
            for (int b = 0; b < 8; b++) begin
                pulse(r, b);
                acc(1'b0, r ? 12'h0ec : 12'h0e8, 0, 32'h1 << b, 1'b0);
                acc(1'b0, r ? 12'h0ec : 12'h0e8, 0, 32'h0, 1'b0);
            end
        end
        // A persisting event survives the clearing read
        @(posedge pclk);
        ev_a <= 8'h90;
        repeat (2) @(posedge pclk);
        acc(1'b0, 12'h0e8, 0, 32'h90, 1'b0);
        acc(1'b0, 12'h0e8, 0, 32'h90, 1'b0);
        ev_a <= 8'h00;
        acc(1'b0, 12'h0e8, 0, 32'h90, 1'b0);
        acc(1'b0, 12'h0e8, 0, 32'h0, 1'b0);
        // A host write must not touch latched flags
        pulse(0, 5);
        acc(1'b1, 12'h0e8, 32'h0, 0, 1'b0);
        acc(1'b0, 12'h0e8, 0, 32'h20, 1'b0);
        // Live flags follow random inputs; reserved bits read zero
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge pclk);
            ev_l <= lfsr;
            repeat (2) @(posedge pclk);
            acc(1'b0, 12'h0f0, 0, {24'h0, lfsr & 8'hf8}, 1'b0);
        end
        acc(1'b1, 12'h0f0, 32'h0, 0, 1'b0);
        acc(1'b0, 12'h0f0, 0, {24'h0, lfsr & 8'hf8}, 1'b0);
        // Unmapped places answer with an error and zero data
        acc(1'b0, 12'h0f4, 0, 32'h0, 1'b1);
        acc(1'b1, 12'h200, 32'hff, 0, 1'b1);
        // Interrupt: clear history, then raise, mask, unmask and clear
        ev_l <= 8'h00;
        acc(1'b1, 12'h100, 32'h7, 0, 1'b0);
        acc(1'b0, 12'h100, 0, 32'h0, 1'b0);
        acc(1'b1, 12'h104, 32'h1, 0, 1'b0);
        acc(1'b0, 12'h104, 0, 32'h1, 1'b0);
        pulse(0, 2);
        irq_is(1'b1);
        acc(1'b0, 12'h100, 0, 32'h1, 1'b0);
        acc(1'b1, 12'h104, 32'h0, 0, 1'b0);
        irq_is(1'b0);
        acc(1'b1, 12'h104, 32'h7, 0, 1'b0);
        irq_is(1'b1);
        acc(1'b1, 12'h100, 32'h1, 0, 1'b0);
        irq_is(1'b0);
        pulse(1, 0);
        ev_l <= 8'h08;
        irq_is(1'b1);
        acc(1'b0, 12'h100, 0, 32'h6, 1'b0);
        acc(1'b0, 12'h0ec, 0, 32'h1, 1'b0);
        give_verdict();
    end
endmodule
